// >>> src/tcrb_regs.svh
`ifndef TCRB_REGS_SVH
`define TCRB_REGS_SVH

// Register offsets on the serial register port
`define TCRB_ADDR_DIV_HIGH 8'h00
`define TCRB_ADDR_DIV_LOW 8'h01
`define TCRB_ADDR_PUMP 8'h02
`define TCRB_ADDR_XTAL_REF 8'h05
`define TCRB_ADDR_SYNTH 8'h06
`define TCRB_ADDR_OSC 8'h07
`define TCRB_ADDR_FILTER 8'h08
`define TCRB_ADDR_CTRL 8'h09
`define TCRB_ADDR_SHUTDOWN 8'h0A

// Reset values
`define TCRB_RST_DIV_HIGH 8'h03
`define TCRB_RST_DIV_LOW 8'hB6
`define TCRB_RST_PUMP 8'h00
`define TCRB_RST_XTAL_REF 8'h04
`define TCRB_RST_SYNTH 8'hC0
`define TCRB_RST_OSC 8'hCC
`define TCRB_RST_FILTER 8'h00
`define TCRB_RST_CTRL 8'h00
`define TCRB_RST_SHUTDOWN 8'h00

// Writable bits; the rest are don't-care and kept at zero
`define TCRB_MASK_DIV_HIGH 8'h7F
`define TCRB_MASK_DIV_LOW 8'hFF
`define TCRB_MASK_PUMP 8'hF0
`define TCRB_MASK_XTAL_REF 8'hFF
`define TCRB_MASK_SYNTH 8'hE0
`define TCRB_MASK_OSC 8'hFF
`define TCRB_MASK_FILTER 8'hFF
`define TCRB_MASK_CTRL 8'hAF
`define TCRB_MASK_SHUTDOWN 8'h7F

// Field positions
`define TCRB_PUMP_MIN_PULSE_HI 7
`define TCRB_PUMP_MIN_PULSE_LO 6
`define TCRB_PUMP_LIN_HI 5
`define TCRB_PUMP_LIN_LO 4
`define TCRB_XTAL_DIV_HI 7
`define TCRB_XTAL_DIV_LO 5
`define TCRB_REF_DIV_HI 4
`define TCRB_REF_DIV_LO 0
`define TCRB_LO_DIV_BIT 7
`define TCRB_PUMP_SRC_BIT 6
`define TCRB_PUMP_HIGH_BIT 5
`define TCRB_OSC_BAND_HI 7
`define TCRB_OSC_BAND_LO 3
`define TCRB_AUTO_BAND_BIT 2
`define TCRB_ADC_LATCH_BIT 1
`define TCRB_ADC_READ_BIT 0
`define TCRB_STANDBY_BIT 7
`define TCRB_FACTORY_PD_BIT 5
`define TCRB_GAIN_HI 3
`define TCRB_GAIN_LO 0
`define TCRB_SD_SYNTH_BIT 6
`define TCRB_SD_DIVIDER_BIT 5
`define TCRB_SD_OSC_BIT 4
`define TCRB_SD_BASEBAND_BIT 3
`define TCRB_SD_MIXER_BIT 2
`define TCRB_SD_RF_GAIN_BIT 1
`define TCRB_SD_FRONT_END_BIT 0

// Divider range and filter corner arithmetic
`define TCRB_N_MIN 15'h0010
`define TCRB_N_MAX 15'h087F
`define TCRB_LPF_BASE_KHZ 17'h0_0FA0
`define TCRB_LPF_OFFSET_CODE 17'h0_000C
`define TCRB_LPF_STEP_KHZ 17'h0_0122

// Timing
`define TCRB_CLK_MHZ 200
`define TCRB_POWERUP_US 100

`endif

// >>> src/tcrb_pkg.sv
package tcrb_pkg;

  typedef logic [7:0] tcrb_byte_t;
  typedef logic [14:0] tcrb_ndiv_t;
  typedef logic [4:0] tcrb_band_t;
  typedef logic [16:0] tcrb_khz_t;

endpackage

// >>> src/tcrb_byte_reg.sv
`timescale 1ns/1ps

module tcrb_byte_reg #(
  parameter logic [7:0] ADDR = 8'h00,
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hFF
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Byte write port
  input wire logic wr_valid_i,
  input wire tcrb_pkg::tcrb_byte_t wr_addr_i,
  input wire tcrb_pkg::tcrb_byte_t wr_data_i,
  // Stored value
  output tcrb_pkg::tcrb_byte_t value_o
);

  tcrb_pkg::tcrb_byte_t value_q;
  tcrb_pkg::tcrb_byte_t value_d;

  always_comb begin
    value_d = value_q;
    if (wr_valid_i && (wr_addr_i == ADDR)) begin
      value_d = wr_data_i & WR_MASK;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      value_q <= RESET_VAL;
    end else begin
      value_q <= value_d;
    end
  end

  assign value_o = value_q;

endmodule

// >>> src/tcrb_top.sv
// What this block does
// - Divide value is high register bits 6..0 above the low register byte.
// - Divide value resets to 950; host keeps it within 16 to 2175.
// - Pump linearity field resets to 00, balanced currents; host keeps 00.
// - Crystal output divide code picks ratio 1 to 8; resets to divide by 1.
// - Reference divide field sets reference ratio; resets to 4, max 31.
// - LO divide bit picks 2 or 4, resets to 4; host uses 2 above 1125MHz.
// - Pump source bit resets to 1; 0 uses pump current bit, 1 auto logic.
// - Oscillator band field picks manual band and auto start band; resets 11001.
// - Auto band enable resets to 1; at 0 band comes only from the register.
// - With auto band off, latch bit latches tuning ADC value; resets 0.
// - With auto band off, read bit enables tuning ADC reads; resets 0.
// - Filter corner is 4MHz plus code minus 12 times 290kHz.
// - Standby disables signal path and synthesizer; crystal parts stay on.
// - Baseband gain code steps about 1dB, 0000 minimum, 1111 maximum.
// - Each shutdown bit powers down one block; all reset to 0.
`timescale 1ns/1ps
`include "tcrb_regs.svh"

module tcrb_top #(
  parameter int POWERUP_CYCLES = `TCRB_POWERUP_US * `TCRB_CLK_MHZ,
  parameter logic [7:0] FILTER_RESET = `TCRB_RST_FILTER
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Byte writes from the serial front end
  input wire logic wr_valid_i,
  input wire tcrb_pkg::tcrb_byte_t wr_addr_i,
  input wire tcrb_pkg::tcrb_byte_t wr_data_i,
  // From the automatic band-select logic
  input wire tcrb_pkg::tcrb_band_t auto_band_i,
  input wire logic auto_pump_high_i,
  // Synthesizer divider
  output tcrb_pkg::tcrb_ndiv_t n_divide_o,
  output logic n_divide_out_of_range_o,
  // Charge pump
  output logic [1:0] pump_min_pulse_o,
  output logic [1:0] pump_linearity_o,
  output logic pump_current_source_select_o,
  output logic pump_current_high_o,
  output logic pump_current_eff_high_o,
  // Crystal and reference dividers
  output logic [2:0] crystal_out_divide_o,
  output logic [3:0] crystal_out_ratio_o,
  output logic [4:0] ref_divide_o,
  // LO divider
  output logic lo_divide_select_o,
  output logic [2:0] lo_divide_ratio_o,
  // Oscillator band and tuning ADC
  output tcrb_pkg::tcrb_band_t osc_band_code_o,
  output logic auto_band_select_enable_o,
  output tcrb_pkg::tcrb_band_t active_band_o,
  output logic tune_adc_latch_o,
  output logic tune_adc_read_o,
  // Baseband filter and gain
  output tcrb_pkg::tcrb_byte_t filter_corner_code_o,
  output tcrb_pkg::tcrb_khz_t filter_corner_khz_o,
  output logic [3:0] baseband_gain_o,
  // Power control
  output logic standby_o,
  output logic factory_power_down_o,
  output logic synth_loop_off_o,
  output logic divider_off_o,
  output logic oscillator_off_o,
  output logic baseband_off_o,
  output logic mixer_off_o,
  output logic rf_gain_stage_off_o,
  output logic front_end_off_o,
  // Power-up settle status
  output logic write_window_open_o
);

  localparam int PU_W = $clog2(POWERUP_CYCLES + 1);
  // Top bit of the high byte is don't-care, so the cast drops it
  localparam logic [14:0] NDIV_RESET = 15'({`TCRB_RST_DIV_HIGH, `TCRB_RST_DIV_LOW});

  tcrb_pkg::tcrb_byte_t div_high;
  tcrb_pkg::tcrb_byte_t div_low;
  tcrb_pkg::tcrb_byte_t pump_reg;
  tcrb_pkg::tcrb_byte_t xtal_ref;
  tcrb_pkg::tcrb_byte_t synth_reg;
  tcrb_pkg::tcrb_byte_t osc_reg;
  tcrb_pkg::tcrb_byte_t filter_reg;
  tcrb_pkg::tcrb_byte_t ctrl_reg;
  tcrb_pkg::tcrb_byte_t shutdown_reg;

  // Register file; unlisted offsets (unused and test) are accepted and dropped
  tcrb_byte_reg #(
    .ADDR(`TCRB_ADDR_DIV_HIGH),
    .RESET_VAL(`TCRB_RST_DIV_HIGH),
    .WR_MASK(`TCRB_MASK_DIV_HIGH)
  ) u_div_high (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_valid_i(wr_valid_i),
    .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i),
    .value_o(div_high)
  );

  tcrb_byte_reg #(
    .ADDR(`TCRB_ADDR_DIV_LOW),
    .RESET_VAL(`TCRB_RST_DIV_LOW),
    .WR_MASK(`TCRB_MASK_DIV_LOW)
  ) u_div_low (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_valid_i(wr_valid_i),
    .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i),
    .value_o(div_low)
  );

  tcrb_byte_reg #(
    .ADDR(`TCRB_ADDR_PUMP),
    .RESET_VAL(`TCRB_RST_PUMP),
    .WR_MASK(`TCRB_MASK_PUMP)
  ) u_pump (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_valid_i(wr_valid_i),
    .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i),
    .value_o(pump_reg)
  );

  tcrb_byte_reg #(
    .ADDR(`TCRB_ADDR_XTAL_REF),
    .RESET_VAL(`TCRB_RST_XTAL_REF),
    .WR_MASK(`TCRB_MASK_XTAL_REF)
  ) u_xtal_ref (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_valid_i(wr_valid_i),
    .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i),
    .value_o(xtal_ref)
  );

  tcrb_byte_reg #(
    .ADDR(`TCRB_ADDR_SYNTH),
    .RESET_VAL(`TCRB_RST_SYNTH),
    .WR_MASK(`TCRB_MASK_SYNTH)
  ) u_synth (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_valid_i(wr_valid_i),
    .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i),
    .value_o(synth_reg)
  );

  tcrb_byte_reg #(
    .ADDR(`TCRB_ADDR_OSC),
    .RESET_VAL(`TCRB_RST_OSC),
    .WR_MASK(`TCRB_MASK_OSC)
  ) u_osc (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_valid_i(wr_valid_i),
    .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i),
    .value_o(osc_reg)
  );

  tcrb_byte_reg #(
    .ADDR(`TCRB_ADDR_FILTER),
    .RESET_VAL(FILTER_RESET),
    .WR_MASK(`TCRB_MASK_FILTER)
  ) u_filter (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_valid_i(wr_valid_i),
    .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i),
    .value_o(filter_reg)
  );

  tcrb_byte_reg #(
    .ADDR(`TCRB_ADDR_CTRL),
    .RESET_VAL(`TCRB_RST_CTRL),
    .WR_MASK(`TCRB_MASK_CTRL)
  ) u_ctrl (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_valid_i(wr_valid_i),
    .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i),
    .value_o(ctrl_reg)
  );

  tcrb_byte_reg #(
    .ADDR(`TCRB_ADDR_SHUTDOWN),
    .RESET_VAL(`TCRB_RST_SHUTDOWN),
    .WR_MASK(`TCRB_MASK_SHUTDOWN)
  ) u_shutdown (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_valid_i(wr_valid_i),
    .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i),
    .value_o(shutdown_reg)
  );

  // Power-up settle counter; status only, early writes are still taken
  logic [PU_W-1:0] pu_count_q;
  logic [PU_W-1:0] pu_count_d;
  logic window_d;

  always_comb begin
    pu_count_d = pu_count_q;
    // Saturates, so the flag stays up until the next reset
    if (pu_count_q != PU_W'(POWERUP_CYCLES)) begin
      pu_count_d = pu_count_q + PU_W'(1);
    end
    window_d = (pu_count_d == PU_W'(POWERUP_CYCLES));
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pu_count_q <= '0;
    end else begin
      pu_count_q <= pu_count_d;
    end
  end

  // Decoded controls, all registered once more so outputs are flops
  tcrb_pkg::tcrb_ndiv_t n_div_d;
  logic n_range_d;
  logic [3:0] xtal_ratio_d;
  logic [2:0] lo_ratio_d;
  logic pump_eff_d;
  logic auto_band_d;
  tcrb_pkg::tcrb_band_t band_d;
  logic adc_latch_d;
  logic adc_read_d;
  tcrb_pkg::tcrb_khz_t khz_d;
  logic standby_d;
  logic [6:0] off_d;

  always_comb begin
    n_div_d = {div_high[6:0], div_low};
    // Range flag is advisory; out-of-range values are still applied
    n_range_d = (n_div_d < `TCRB_N_MIN) || (n_div_d > `TCRB_N_MAX);
    xtal_ratio_d = {1'b0, xtal_ref[`TCRB_XTAL_DIV_HI:`TCRB_XTAL_DIV_LO]} + 4'h1;
    lo_ratio_d = synth_reg[`TCRB_LO_DIV_BIT] ? 3'h4 : 3'h2;
    if (synth_reg[`TCRB_PUMP_SRC_BIT]) begin
      pump_eff_d = auto_pump_high_i;
    end else begin
      pump_eff_d = synth_reg[`TCRB_PUMP_HIGH_BIT];
    end
    // Auto mode lags the selector input by one flop
    auto_band_d = osc_reg[`TCRB_AUTO_BAND_BIT];
    if (auto_band_d) begin
      band_d = auto_band_i;
    end else begin
      band_d = osc_reg[`TCRB_OSC_BAND_HI:`TCRB_OSC_BAND_LO];
    end
    adc_latch_d = !auto_band_d && osc_reg[`TCRB_ADC_LATCH_BIT];
    adc_read_d = !auto_band_d && osc_reg[`TCRB_ADC_READ_BIT];
    // Codes below 12 still give a positive corner, so unsigned math is safe
    khz_d = `TCRB_LPF_BASE_KHZ + (17'(filter_reg) * `TCRB_LPF_STEP_KHZ)
            - (`TCRB_LPF_OFFSET_CODE * `TCRB_LPF_STEP_KHZ);
    standby_d = ctrl_reg[`TCRB_STANDBY_BIT];
    // Standby forces signal path and synthesizer off; crystal side untouched
    off_d = shutdown_reg[`TCRB_SD_SYNTH_BIT:`TCRB_SD_FRONT_END_BIT] | {7{standby_d}};
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      // Decoded forms of the register reset bytes, except filter_corner_khz_o, which loads 0
      n_divide_o <= NDIV_RESET;
      n_divide_out_of_range_o <= 1'b0;
      pump_min_pulse_o <= 2'h0;
      pump_linearity_o <= 2'h0;
      pump_current_source_select_o <= 1'b1;
      pump_current_high_o <= 1'b0;
      pump_current_eff_high_o <= 1'b0;
      crystal_out_divide_o <= 3'h0;
      crystal_out_ratio_o <= 4'h1;
      ref_divide_o <= 5'h04;
      lo_divide_select_o <= 1'b1;
      lo_divide_ratio_o <= 3'h4;
      osc_band_code_o <= 5'h19;
      auto_band_select_enable_o <= 1'b1;
      active_band_o <= 5'h19;
      tune_adc_latch_o <= 1'b0;
      tune_adc_read_o <= 1'b0;
      filter_corner_code_o <= 8'h00;
      filter_corner_khz_o <= 17'h0_0000;
      baseband_gain_o <= 4'h0;
      standby_o <= 1'b0;
      factory_power_down_o <= 1'b0;
      synth_loop_off_o <= 1'b0;
      divider_off_o <= 1'b0;
      oscillator_off_o <= 1'b0;
      baseband_off_o <= 1'b0;
      mixer_off_o <= 1'b0;
      rf_gain_stage_off_o <= 1'b0;
      front_end_off_o <= 1'b0;
      write_window_open_o <= 1'b0;
    end else begin
      n_divide_o <= n_div_d;
      n_divide_out_of_range_o <= n_range_d;
      pump_min_pulse_o <= pump_reg[`TCRB_PUMP_MIN_PULSE_HI:`TCRB_PUMP_MIN_PULSE_LO];
      pump_linearity_o <= pump_reg[`TCRB_PUMP_LIN_HI:`TCRB_PUMP_LIN_LO];
      pump_current_source_select_o <= synth_reg[`TCRB_PUMP_SRC_BIT];
      pump_current_high_o <= synth_reg[`TCRB_PUMP_HIGH_BIT];
      pump_current_eff_high_o <= pump_eff_d;
      crystal_out_divide_o <= xtal_ref[`TCRB_XTAL_DIV_HI:`TCRB_XTAL_DIV_LO];
      crystal_out_ratio_o <= xtal_ratio_d;
      ref_divide_o <= xtal_ref[`TCRB_REF_DIV_HI:`TCRB_REF_DIV_LO];
      lo_divide_select_o <= synth_reg[`TCRB_LO_DIV_BIT];
      lo_divide_ratio_o <= lo_ratio_d;
      osc_band_code_o <= osc_reg[`TCRB_OSC_BAND_HI:`TCRB_OSC_BAND_LO];
      auto_band_select_enable_o <= auto_band_d;
      active_band_o <= band_d;
      tune_adc_latch_o <= adc_latch_d;
      tune_adc_read_o <= adc_read_d;
      filter_corner_code_o <= filter_reg;
      filter_corner_khz_o <= khz_d;
      baseband_gain_o <= ctrl_reg[`TCRB_GAIN_HI:`TCRB_GAIN_LO];
      standby_o <= standby_d;
      factory_power_down_o <= ctrl_reg[`TCRB_FACTORY_PD_BIT];
      synth_loop_off_o <= off_d[`TCRB_SD_SYNTH_BIT];
      divider_off_o <= off_d[`TCRB_SD_DIVIDER_BIT];
      oscillator_off_o <= off_d[`TCRB_SD_OSC_BIT];
      baseband_off_o <= off_d[`TCRB_SD_BASEBAND_BIT];
      mixer_off_o <= off_d[`TCRB_SD_MIXER_BIT];
      rf_gain_stage_off_o <= off_d[`TCRB_SD_RF_GAIN_BIT];
      front_end_off_o <= off_d[`TCRB_SD_FRONT_END_BIT];
      write_window_open_o <= window_d;
    end
  end

endmodule

// >>> verification/tcrb_top_chk.sv
`timescale 1ns/1ps

module tcrb_top_chk (
  // Clock, reset and write port
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic wr_valid_i,
  input wire tcrb_pkg::tcrb_byte_t wr_addr_i,
  input wire tcrb_pkg::tcrb_byte_t wr_data_i,
  input wire tcrb_pkg::tcrb_band_t auto_band_i,
  input wire logic auto_pump_high_i,
  // Decoded outputs
  input wire tcrb_pkg::tcrb_ndiv_t n_divide_o,
  input wire logic pump_current_source_select_o,
  input wire logic pump_current_high_o,
  input wire logic pump_current_eff_high_o,
  input wire logic [2:0] crystal_out_divide_o,
  input wire logic [3:0] crystal_out_ratio_o,
  input wire logic lo_divide_select_o,
  input wire logic [2:0] lo_divide_ratio_o,
  input wire tcrb_pkg::tcrb_band_t osc_band_code_o,
  input wire logic auto_band_select_enable_o,
  input wire tcrb_pkg::tcrb_band_t active_band_o,
  input wire logic tune_adc_latch_o,
  input wire tcrb_pkg::tcrb_byte_t filter_corner_code_o,
  input wire tcrb_pkg::tcrb_khz_t filter_corner_khz_o,
  input wire logic standby_o,
  input wire logic front_end_off_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  ndiv_low_a: assert property (
    wr_valid_i && wr_addr_i == 8'h01 ##1 !(wr_valid_i && wr_addr_i == 8'h01)
    |-> ##1 n_divide_o[7:0] == $past(wr_data_i, 2)) else $error("low divider byte not applied");
  ndiv_high_a: assert property (
    wr_valid_i && wr_addr_i == 8'h00 ##1 !(wr_valid_i && wr_addr_i == 8'h00)
    |-> ##1 n_divide_o[14:8] == 7'($past(wr_data_i, 2))) else $error("high divider bits not applied");
  standby_on_a: assert property (
    wr_valid_i && wr_addr_i == 8'h09 && wr_data_i[7] ##1 !(wr_valid_i && wr_addr_i == 8'h09)
    |-> ##1 standby_o && front_end_off_o) else $error("standby did not take effect");
  front_off_a: assert property (
    wr_valid_i && wr_addr_i == 8'h0A ##1 !(wr_valid_i && wr_addr_i == 8'h0A)
    |-> ##1 front_end_off_o == (standby_o || ($past(wr_data_i, 2) & 8'h01) != 8'h00))
    else $error("front end shutdown mismatch");
  lo_ratio_a: assert property (
    lo_divide_ratio_o == (lo_divide_select_o ? 3'h4 : 3'h2)) else $error("lo ratio mismatch");
  xtal_ratio_a: assert property (
    crystal_out_ratio_o == {1'b0, crystal_out_divide_o} + 4'h1) else $error("crystal ratio mismatch");
  auto_band_a: assert property (
    !$past(rst_i) && auto_band_select_enable_o && $past(auto_band_select_enable_o)
    |-> active_band_o == $past(auto_band_i)) else $error("auto band not followed");
  manual_band_a: assert property (
    !auto_band_select_enable_o |-> active_band_o == osc_band_code_o) else $error("manual band mismatch");
  adc_gate_a: assert property (
    tune_adc_latch_o |-> !auto_band_select_enable_o) else $error("adc latch active in auto mode");
  filter_khz_a: assert property (
    !$past(rst_i) |-> filter_corner_khz_o == 17'h0_0FA0 + 17'h0_0122 * {9'h000, filter_corner_code_o}
    - 17'h0_0D98) else $error("filter corner mismatch");
  pump_eff_a: assert property (
    !$past(rst_i) |-> pump_current_eff_high_o ==
    (pump_current_source_select_o ? $past(auto_pump_high_i) : pump_current_high_o))
    else $error("pump current source mismatch");
endmodule

// >>> verification/tcrb_host_model.sv
`timescale 1ns/1ps

module tcrb_host_model (
  // Clock
  input wire logic clock_i,
  // Byte write port
  output logic wr_valid_o,
  output tcrb_pkg::tcrb_byte_t wr_addr_o,
  output tcrb_pkg::tcrb_byte_t wr_data_o
);
  initial begin
    wr_valid_o = 1'b0;
    wr_addr_o = 8'hF0;
    wr_data_o = 8'h5A;
  end

  // One-cycle strobe; caller enters at a falling edge
  task automatic write_byte(input tcrb_pkg::tcrb_byte_t addr, input tcrb_pkg::tcrb_byte_t data);
    wr_addr_o = addr;
    wr_data_o = data;
    wr_valid_o = 1'b1;
    @(negedge clock_i);
    wr_valid_o = 1'b0;
    // No pull on these lines, so stale data must not linger
    wr_addr_o = ~addr;
    wr_data_o = ~data;
  endtask
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ps

module testbench;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_valid_i;
  tcrb_pkg::tcrb_byte_t wr_addr_i, wr_data_i, filter_corner_code_o;
  tcrb_pkg::tcrb_band_t auto_band_i = 5'h0A;
  logic auto_pump_high_i = 1'b0;
  tcrb_pkg::tcrb_ndiv_t n_divide_o;
  tcrb_pkg::tcrb_band_t osc_band_code_o, active_band_o;
  tcrb_pkg::tcrb_khz_t filter_corner_khz_o;
  logic [1:0] pump_min_pulse_o, pump_linearity_o;
  logic [2:0] crystal_out_divide_o, lo_divide_ratio_o;
  logic [3:0] crystal_out_ratio_o, baseband_gain_o;
  logic [4:0] ref_divide_o;
  logic [6:0] offs;
  logic n_divide_out_of_range_o, pump_current_source_select_o, pump_current_high_o, pump_current_eff_high_o;
  logic lo_divide_select_o, auto_band_select_enable_o, tune_adc_latch_o, tune_adc_read_o, standby_o;
  logic factory_power_down_o, synth_loop_off_o, divider_off_o, oscillator_off_o, baseband_off_o;
  logic mixer_off_o, rf_gain_stage_off_o, front_end_off_o, write_window_open_o;
  int n_mismatch = 0;
  int comparisons = 0;

  assign offs = {synth_loop_off_o, divider_off_o, oscillator_off_o, baseband_off_o, mixer_off_o,
    rf_gain_stage_off_o, front_end_off_o};

  tcrb_host_model u_tcrb_host_model (.clock_i(clock_i), .wr_valid_o(wr_valid_i), .wr_addr_o(wr_addr_i),
    .wr_data_o(wr_data_i));
  // Short power-up wait keeps the run brief
  tcrb_top #(
    .POWERUP_CYCLES(20)
  ) u_tcrb_top (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_valid_i(wr_valid_i),
    .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i),
    .auto_band_i(auto_band_i),
    .auto_pump_high_i(auto_pump_high_i),
    .n_divide_o(n_divide_o),
    .n_divide_out_of_range_o(n_divide_out_of_range_o),
    .pump_min_pulse_o(pump_min_pulse_o),
    .pump_linearity_o(pump_linearity_o),
    .pump_current_source_select_o(pump_current_source_select_o),
    .pump_current_high_o(pump_current_high_o),
    .pump_current_eff_high_o(pump_current_eff_high_o),
    .crystal_out_divide_o(crystal_out_divide_o),
    .crystal_out_ratio_o(crystal_out_ratio_o),
    .ref_divide_o(ref_divide_o),
    .lo_divide_select_o(lo_divide_select_o),
    .lo_divide_ratio_o(lo_divide_ratio_o),
    .osc_band_code_o(osc_band_code_o),
    .auto_band_select_enable_o(auto_band_select_enable_o),
    .active_band_o(active_band_o),
    .tune_adc_latch_o(tune_adc_latch_o),
    .tune_adc_read_o(tune_adc_read_o),
    .filter_corner_code_o(filter_corner_code_o),
    .filter_corner_khz_o(filter_corner_khz_o),
    .baseband_gain_o(baseband_gain_o),
    .standby_o(standby_o),
    .factory_power_down_o(factory_power_down_o),
    .synth_loop_off_o(synth_loop_off_o),
    .divider_off_o(divider_off_o),
    .oscillator_off_o(oscillator_off_o),
    .baseband_off_o(baseband_off_o),
    .mixer_off_o(mixer_off_o),
    .rf_gain_stage_off_o(rf_gain_stage_off_o),
    .front_end_off_o(front_end_off_o),
    .write_window_open_o(write_window_open_o)
  );

  always #2.5 clock_i = ~clock_i;

  task automatic chk(input string what, input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Outputs settle one edge after the taking edge
  task automatic put(input tcrb_pkg::tcrb_byte_t addr, input tcrb_pkg::tcrb_byte_t data);
    u_tcrb_host_model.write_byte(addr, data);
    repeat (2) @(negedge clock_i);
  endtask

  task automatic wait_window;
    int n;
    n = 0;
    repeat (18) @(negedge clock_i);
    chk("window early", write_window_open_o, 1'b0);
    while (write_window_open_o !== 1'b1) begin
      if (n == 8) begin
        chk("window open", write_window_open_o, 1'b1);
        test_done();
      end
      n++;
      @(negedge clock_i);
    end
  endtask

  task automatic check_reset;
    chk("divide", n_divide_o, 15'h03B6);
    chk("range", n_divide_out_of_range_o, 1'b0);
    chk("pump", {pump_min_pulse_o, pump_linearity_o, pump_current_source_select_o, pump_current_high_o,
      pump_current_eff_high_o}, 7'h04);
    chk("xtal", {crystal_out_divide_o, crystal_out_ratio_o, ref_divide_o}, 12'h024);
    chk("lo", {lo_divide_select_o, lo_divide_ratio_o}, 4'hC);
    chk("osc", {osc_band_code_o, auto_band_select_enable_o, active_band_o, tune_adc_latch_o,
      tune_adc_read_o}, 13'h19A8);
    chk("khz", filter_corner_khz_o, 17'h0_0208);
    chk("ctrl", {standby_o, factory_power_down_o, baseband_gain_o, offs}, 13'h0000);
  endtask

  task automatic nd(input tcrb_pkg::tcrb_byte_t hi, input tcrb_pkg::tcrb_byte_t lo, input logic [14:0] n,
    input logic f);
    put(8'h00, hi);
    put(8'h01, lo);
    chk("divide", n_divide_o, n);
    chk("range", n_divide_out_of_range_o, f);
  endtask

  task automatic check_divider;
    nd(8'hFF, 8'h7F, 15'h7F7F, 1'b1);
    nd(8'h08, 8'h7F, 15'h087F, 1'b0);
    nd(8'h00, 8'h10, 15'h0010, 1'b0);
    nd(8'h00, 8'h0F, 15'h000F, 1'b1);
    put(8'h03, 8'hFF);
    chk("divide kept", n_divide_o, 15'h000F);
    put(8'h02, 8'h0F);
    chk("pump", {pump_min_pulse_o, pump_linearity_o}, 4'h0);
  endtask

  task automatic check_dividers;
    put(8'h05, 8'hFF);
    chk("xtal", {crystal_out_divide_o, crystal_out_ratio_o, ref_divide_o}, 12'hF1F);
    put(8'h05, 8'h20);
    chk("xtal", {crystal_out_divide_o, crystal_out_ratio_o, ref_divide_o}, 12'h240);
    auto_pump_high_i = 1'b1;
    put(8'h06, 8'h3F);
    chk("lo", {lo_divide_select_o, lo_divide_ratio_o}, 4'h2);
    chk("pump", {pump_current_source_select_o, pump_current_high_o, pump_current_eff_high_o}, 3'h3);
    put(8'h06, 8'hC0);
    chk("pump", {pump_current_source_select_o, pump_current_high_o, pump_current_eff_high_o}, 3'h5);
    auto_pump_high_i = 1'b0;
    repeat (2) @(negedge clock_i);
    chk("pump", {pump_current_source_select_o, pump_current_high_o, pump_current_eff_high_o}, 3'h4);
  endtask

  task automatic check_osc;
    put(8'h07, 8'h5B);
    chk("osc", {osc_band_code_o, auto_band_select_enable_o, active_band_o, tune_adc_latch_o,
      tune_adc_read_o}, 13'h0B2F);
    auto_band_i = 5'h15;
    put(8'h07, 8'h5F);
    chk("osc", {osc_band_code_o, auto_band_select_enable_o, active_band_o, tune_adc_latch_o,
      tune_adc_read_o}, 13'h0BD4);
  endtask

  task automatic check_filter_ctrl;
    put(8'h08, 8'h0C);
    chk("khz", filter_corner_khz_o, 17'h0_0FA0);
    put(8'h08, 8'hFF);
    chk("khz", filter_corner_khz_o, 17'h1_22E6);
    chk("code", filter_corner_code_o, 8'hFF);
    put(8'h09, 8'h8F);
    chk("ctrl", {standby_o, factory_power_down_o, baseband_gain_o, offs}, 13'h17FF);
    put(8'h09, 8'h50);
    chk("ctrl", {standby_o, factory_power_down_o, baseband_gain_o, offs}, 13'h0000);
  endtask

  task automatic check_shutdown;
    for (int i = 0; i < 7; i++) begin
      put(8'h0A, 8'h01 << i);
      chk("shutdown", offs, 7'h01 << i);
    end
    put(8'h0A, 8'h80);
    chk("shutdown", offs, 7'h00);
  endtask

  // Mid-run reset must bring every written register back
  task automatic check_rerun;
    auto_band_i = 5'h0A;
    rst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    wait_window();
    check_reset();
  endtask

  initial begin
    repeat (6) @(negedge clock_i);
    rst_i = 1'b0;
    wait_window();
    check_reset();
    check_divider();
    check_dividers();
    check_osc();
    check_filter_ctrl();
    check_shutdown();
    check_rerun();
    test_done();
  end
endmodule

bind tcrb_top tcrb_top_chk u_tcrb_top_chk (
  .clock_i(clock_i),
  .rst_i(rst_i),
  .wr_valid_i(wr_valid_i),
  .wr_addr_i(wr_addr_i),
  .wr_data_i(wr_data_i),
  .auto_band_i(auto_band_i),
  .auto_pump_high_i(auto_pump_high_i),
  .n_divide_o(n_divide_o),
  .pump_current_source_select_o(pump_current_source_select_o),
  .pump_current_high_o(pump_current_high_o),
  .pump_current_eff_high_o(pump_current_eff_high_o),
  .crystal_out_divide_o(crystal_out_divide_o),
  .crystal_out_ratio_o(crystal_out_ratio_o),
  .lo_divide_select_o(lo_divide_select_o),
  .lo_divide_ratio_o(lo_divide_ratio_o),
  .osc_band_code_o(osc_band_code_o),
  .auto_band_select_enable_o(auto_band_select_enable_o),
  .active_band_o(active_band_o),
  .tune_adc_latch_o(tune_adc_latch_o),
  .filter_corner_code_o(filter_corner_code_o),
  .filter_corner_khz_o(filter_corner_khz_o),
  .standby_o(standby_o),
  .front_end_off_o(front_end_off_o)
);
